//--- src/cssso_core.sv
// Summary of operation
// - push accumulator, decrement stack, 3 cycles
// - push status, decrement stack, 3 cycles
// - increment stack, pull accumulator, 4 cycles
// - increment stack, pull status, 4 cycles
// - rotate left through carry, 2/5 cycles
// - rotate right through carry, 2/5 cycles
// - swap zero-page nibbles, no flags, 8 cycles
// - interrupt return pulls status, pc low, high
// - subroutine return pulls pc low, high
// - subtract with borrow into accumulator
// - index mode writes result to M(X), +3
// - set one selected bit of A or memory
// - set carry, decimal, interrupt disable flags
// - index mode on sets status bit five
// - slow clock detaches fast clock pin
// - oscillator halt stops the oscillator
// - store accumulator, no flags, 4 cycles
// - store index x or y, 4 cycles
// - accumulator to x or y, sets N Z
// - zero-page zero test sets N Z
// - stack pointer and x transfers
// - x or y to accumulator, sets N Z
`include "cssso_regs.svh"
module cssso_core
  import cssso_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // memory bus, one access per cycle, read data combinational
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  input  wire logic [7:0]  mem_rdata,
  // clock control and state
  output logic             fast_clock_output_pin_en,
  output logic             osc_run,
  output logic             instr_done,
  output logic      [7:0]  acc,
  output logic      [7:0]  index_x,
  output logic      [7:0]  index_y,
  output logic      [7:0]  stack_ptr,
  output logic      [7:0]  status,
  output logic      [15:0] prog_cnt
);
  cssso_state_e state;
  cssso_state_e next_state;
  logic [7:0]  opcode;
  logic [7:0]  next_opcode;
  logic [7:0]  oper;
  logic [7:0]  next_oper;
  logic [3:0]  cyc;
  logic [3:0]  next_cyc;
  logic [7:0]  next_acc;
  logic [7:0]  next_index_x;
  logic [7:0]  next_index_y;
  logic [7:0]  next_stack_ptr;
  logic [7:0]  next_status;
  logic [15:0] next_prog_cnt;
  logic        next_fast_en;
  logic        next_osc_run;
  logic [7:0]  alu_a;
  logic [7:0]  alu_m;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_v;
  logic        alu_cv;
  logic [3:0]  total;
  logic        t_mode;
  logic        is_seb_a;
  logic        is_seb_zp;
  logic        zp_rmw;

  assign t_mode    = status[`CSSSO_BIT_T];
  assign is_seb_a  = (opcode[4:0] == `CSSSO_SEB_A_LOW);
  assign is_seb_zp = (opcode[4:0] == `CSSSO_SEB_ZP_LOW);
  assign zp_rmw    = (opcode == `CSSSO_OP_ROL_ZP) ||
                     (opcode == `CSSSO_OP_ROR_ZP) ||
                     (opcode == `CSSSO_OP_NIB_ZP) || is_seb_zp;

  cssso_alu u_alu (
    .op      (opcode),
    .a_in    (alu_a),
    .m_in    (alu_m),
    .c_in    (status[`CSSSO_BIT_C]),
    .res     (alu_res),
    .c_out   (alu_c),
    .v_out   (alu_v),
    .c_valid (alu_cv),
    .v_valid ()
  );

  // cycle totals per opcode, counting the fetch cycle
  always_comb begin
    case (opcode)
      `CSSSO_OP_PUSH_ACC, `CSSSO_OP_PUSH_ST: total = 4'd3;
      `CSSSO_OP_PULL_ACC, `CSSSO_OP_PULL_ST: total = 4'd4;
      `CSSSO_OP_ROL_ZP, `CSSSO_OP_ROR_ZP:    total = 4'd5;
      `CSSSO_OP_NIB_ZP:                      total = 4'd8;
      `CSSSO_OP_IRQ_RET, `CSSSO_OP_SUB_RET:  total = 4'd6;
      `CSSSO_OP_SBC_IMM:
        total = t_mode ? 4'd2 + `CSSSO_T_EXTRA : 4'd2;
      `CSSSO_OP_SBC_ZP:
        total = t_mode ? 4'd3 + `CSSSO_T_EXTRA : 4'd3;
      `CSSSO_OP_STA_ZP, `CSSSO_OP_STX_ZP,
      `CSSSO_OP_STY_ZP:                      total = 4'd4;
      `CSSSO_OP_TST_ZP:                      total = 4'd3;
      default: total = is_seb_zp ? 4'd5 : 4'd2;
    endcase
  end

  always_comb begin
    next_state     = state;
    next_opcode    = opcode;
    next_oper      = oper;
    next_cyc       = cyc;
    next_acc       = acc;
    next_index_x   = index_x;
    next_index_y   = index_y;
    next_stack_ptr = stack_ptr;
    next_status    = status;
    next_prog_cnt  = prog_cnt;
    next_fast_en   = fast_clock_output_pin_en;
    next_osc_run   = osc_run;
    mem_addr       = prog_cnt;
    mem_wdata      = 8'h00;
    mem_we         = 1'b0;
    instr_done     = 1'b0;
    alu_a          = acc;
    alu_m          = acc;
    case (state)
      CSSSO_FETCH: begin
        next_opcode   = mem_rdata;
        next_prog_cnt = prog_cnt + 16'h0001;
        next_cyc      = 4'd2;
        next_state    = CSSSO_OPER;
      end
      CSSSO_OPER: begin
        // cycle 2: operand fetch, idle for stack and return ops, or one-byte execute
        next_cyc   = cyc + 4'd1;
        next_state = CSSSO_EXEC;
        case (opcode)
          `CSSSO_OP_PUSH_ACC, `CSSSO_OP_PUSH_ST,
          `CSSSO_OP_PULL_ACC, `CSSSO_OP_PULL_ST,
          `CSSSO_OP_IRQ_RET, `CSSSO_OP_SUB_RET: ;
          `CSSSO_OP_ROL_ZP, `CSSSO_OP_ROR_ZP, `CSSSO_OP_NIB_ZP,
          `CSSSO_OP_SBC_IMM, `CSSSO_OP_SBC_ZP, `CSSSO_OP_STA_ZP,
          `CSSSO_OP_STX_ZP, `CSSSO_OP_STY_ZP, `CSSSO_OP_TST_ZP: begin
            next_oper     = mem_rdata;
            next_prog_cnt = prog_cnt + 16'h0001;
          end
          default: begin
            if (is_seb_zp) begin
              next_oper     = mem_rdata;
              next_prog_cnt = prog_cnt + 16'h0001;
            end
          end
        endcase
        if (cyc == total) begin
          next_state = CSSSO_FETCH;
          instr_done = 1'b1;
          case (opcode)
            `CSSSO_OP_ROL_A, `CSSSO_OP_ROR_A: begin
              next_acc = alu_res;
              next_status[`CSSSO_BIT_C] = alu_c;
              next_status[`CSSSO_BIT_N] = alu_res[7];
              next_status[`CSSSO_BIT_Z] = (alu_res == 8'h00);
            end
            `CSSSO_OP_SBC_IMM: begin
              alu_m    = mem_rdata;
              next_acc = alu_res;
              next_status[`CSSSO_BIT_C] = alu_c;
              next_status[`CSSSO_BIT_V] = alu_v;
              next_status[`CSSSO_BIT_N] = alu_res[7];
              next_status[`CSSSO_BIT_Z] = (alu_res == 8'h00);
            end
            `CSSSO_OP_SET_C: next_status[`CSSSO_BIT_C] = 1'b1;
            `CSSSO_OP_SET_D: next_status[`CSSSO_BIT_D] = 1'b1;
            `CSSSO_OP_SET_I: next_status[`CSSSO_BIT_I] = 1'b1;
            `CSSSO_OP_SET_T: next_status[`CSSSO_BIT_T] = 1'b1;
            `CSSSO_OP_SLOW:  next_fast_en = 1'b0;
            `CSSSO_OP_HALT: begin
              next_osc_run = 1'b0;
              next_state   = CSSSO_HALT;
            end
            `CSSSO_OP_TAX: begin
              next_index_x = acc;
              next_status[`CSSSO_BIT_N] = acc[7];
              next_status[`CSSSO_BIT_Z] = (acc == 8'h00);
            end
            `CSSSO_OP_TAY: begin
              next_index_y = acc;
              next_status[`CSSSO_BIT_N] = acc[7];
              next_status[`CSSSO_BIT_Z] = (acc == 8'h00);
            end
            `CSSSO_OP_TSX: next_index_x = stack_ptr;
            `CSSSO_OP_TXS: next_stack_ptr = index_x;
            `CSSSO_OP_TXA: begin
              next_acc = index_x;
              next_status[`CSSSO_BIT_N] = index_x[7];
              next_status[`CSSSO_BIT_Z] = (index_x == 8'h00);
            end
            `CSSSO_OP_TYA: begin
              next_acc = index_y;
              next_status[`CSSSO_BIT_N] = index_y[7];
              next_status[`CSSSO_BIT_Z] = (index_y == 8'h00);
            end
            default: begin
              // seb on accumulator; unknown opcodes act as 2-cycle no-ops
              if (is_seb_a)
                next_acc = alu_res;
            end
          endcase
        end
      end
      CSSSO_EXEC: begin
        next_cyc = cyc + 4'd1;
        if (cyc == total) begin
          next_state = CSSSO_FETCH;
          instr_done = 1'b1;
        end
        mem_addr = {8'h00, oper};
        case (opcode)
          `CSSSO_OP_PUSH_ACC, `CSSSO_OP_PUSH_ST: begin
            mem_addr  = {`CSSSO_STACK_PAGE, stack_ptr};
            mem_wdata = (opcode == `CSSSO_OP_PUSH_ACC) ? acc : status;
            mem_we    = 1'b1;
            next_stack_ptr = stack_ptr - 8'h01;
          end
          `CSSSO_OP_PULL_ACC, `CSSSO_OP_PULL_ST: begin
            mem_addr = {`CSSSO_STACK_PAGE, stack_ptr};
            if (cyc == 4'd3)
              next_stack_ptr = stack_ptr + 8'h01;
            else if (opcode == `CSSSO_OP_PULL_ACC) begin
              next_acc = mem_rdata;
              next_status[`CSSSO_BIT_N] = mem_rdata[7];
              next_status[`CSSSO_BIT_Z] = (mem_rdata == 8'h00);
            end else
              next_status = mem_rdata;
          end
          `CSSSO_OP_IRQ_RET, `CSSSO_OP_SUB_RET: begin
            // bump and read share a cycle so three pulls fit in six
            mem_addr = {`CSSSO_STACK_PAGE, stack_ptr + 8'h01};
            if (cyc >= ((opcode == `CSSSO_OP_IRQ_RET) ? 4'd4 : 4'd5))
              next_stack_ptr = stack_ptr + 8'h01;
            if (cyc == total)
              next_prog_cnt[15:8] = mem_rdata;
            else if (cyc == total - 4'd1)
              next_prog_cnt[7:0] = mem_rdata;
            else if (opcode == `CSSSO_OP_IRQ_RET && cyc == 4'd4)
              next_status = mem_rdata;
          end
          `CSSSO_OP_STA_ZP, `CSSSO_OP_STX_ZP, `CSSSO_OP_STY_ZP: begin
            if (cyc == total) begin
              mem_we    = 1'b1;
              mem_wdata = (opcode == `CSSSO_OP_STA_ZP) ? acc :
                          (opcode == `CSSSO_OP_STX_ZP) ? index_x : index_y;
            end
          end
          `CSSSO_OP_TST_ZP: begin
            next_status[`CSSSO_BIT_N] = mem_rdata[7];
            next_status[`CSSSO_BIT_Z] = (mem_rdata == 8'h00);
          end
          `CSSSO_OP_SBC_IMM, `CSSSO_OP_SBC_ZP: begin
            // index mode parks M in oper, then rewrites M(X) in place
            if (t_mode && opcode == `CSSSO_OP_SBC_ZP && cyc == 4'd3)
              next_oper = mem_rdata;
            if (cyc == total) begin
              alu_m = mem_rdata;
              if (t_mode) begin
                mem_addr  = {8'h00, index_x};
                alu_a     = mem_rdata;
                alu_m     = oper;
                mem_we    = 1'b1;
                mem_wdata = alu_res;
              end else
                next_acc = alu_res;
              next_status[`CSSSO_BIT_C] = alu_c;
              next_status[`CSSSO_BIT_V] = alu_v;
              next_status[`CSSSO_BIT_N] = alu_res[7];
              next_status[`CSSSO_BIT_Z] = (alu_res == 8'h00);
            end
          end
          default: begin
            // zero-page read-modify-write: read, modify, write last cycle
            if (zp_rmw && cyc == total) begin
              alu_m     = mem_rdata;
              mem_we    = 1'b1;
              mem_wdata = alu_res;
              if (alu_cv) begin
                next_status[`CSSSO_BIT_C] = alu_c;
                next_status[`CSSSO_BIT_N] = alu_res[7];
                next_status[`CSSSO_BIT_Z] = (alu_res == 8'h00);
              end
            end
          end
        endcase
      end
      CSSSO_HALT: next_state = CSSSO_HALT;
      default:    next_state = CSSSO_FETCH;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state     <= CSSSO_FETCH;
      opcode    <= 8'h00;
      oper      <= 8'h00;
      cyc       <= 4'd1;
      acc       <= 8'h00;
      index_x   <= 8'h00;
      index_y   <= 8'h00;
      stack_ptr <= `CSSSO_SP_RESET;
      status    <= `CSSSO_PS_RESET;
      prog_cnt  <= 16'h0000;
      fast_clock_output_pin_en <= 1'b1;
      osc_run   <= 1'b1;
    end else begin
      state     <= next_state;
      opcode    <= next_opcode;
      oper      <= next_oper;
      cyc       <= next_cyc;
      acc       <= next_acc;
      index_x   <= next_index_x;
      index_y   <= next_index_y;
      stack_ptr <= next_stack_ptr;
      status    <= next_status;
      prog_cnt  <= next_prog_cnt;
      fast_clock_output_pin_en <= next_fast_en;
      osc_run   <= next_osc_run;
    end
  end
endmodule

//--- src/cssso_regs.svh
`ifndef CSSSO_REGS_SVH
`define CSSSO_REGS_SVH
`define CSSSO_OP_PUSH_ACC   8'h48
`define CSSSO_OP_PUSH_ST    8'h08
`define CSSSO_OP_PULL_ACC   8'h68
`define CSSSO_OP_PULL_ST    8'h28
`define CSSSO_OP_ROL_A      8'h2a
`define CSSSO_OP_ROL_ZP     8'h26
`define CSSSO_OP_ROR_A      8'h6a
`define CSSSO_OP_ROR_ZP     8'h66
`define CSSSO_OP_NIB_ZP     8'h82
`define CSSSO_OP_IRQ_RET    8'h40
`define CSSSO_OP_SUB_RET    8'h60
`define CSSSO_OP_SBC_IMM    8'he9
`define CSSSO_OP_SBC_ZP     8'he5
`define CSSSO_OP_SET_C      8'h38
`define CSSSO_OP_SET_D      8'hf8
`define CSSSO_OP_SET_I      8'h78
`define CSSSO_OP_SET_T      8'h32
`define CSSSO_OP_SLOW       8'hc2
`define CSSSO_OP_HALT       8'h42
`define CSSSO_OP_STA_ZP     8'h85
`define CSSSO_OP_STX_ZP     8'h86
`define CSSSO_OP_STY_ZP     8'h84
`define CSSSO_OP_TAX        8'haa
`define CSSSO_OP_TAY        8'ha8
`define CSSSO_OP_TST_ZP     8'h64
`define CSSSO_OP_TSX        8'hba
`define CSSSO_OP_TXS        8'h9a
`define CSSSO_OP_TYA        8'h98
`define CSSSO_OP_TXA        8'h8a
`define CSSSO_SEB_A_LOW     5'h0b
`define CSSSO_SEB_ZP_LOW    5'h0f
`define CSSSO_SP_RESET      8'hff
`define CSSSO_PS_RESET      8'h04
`define CSSSO_STACK_PAGE    8'h01
`define CSSSO_T_EXTRA       4'h3
`define CSSSO_BIT_C         0
`define CSSSO_BIT_Z         1
`define CSSSO_BIT_I         2
`define CSSSO_BIT_D         3
`define CSSSO_BIT_T         5
`define CSSSO_BIT_V         6
`define CSSSO_BIT_N         7
`endif

//--- src/cssso_pkg.sv
package cssso_pkg;
  typedef enum logic [3:0] {
    CSSSO_FETCH = 4'b0001,
    CSSSO_OPER  = 4'b0010,
    CSSSO_EXEC  = 4'b0100,
    CSSSO_HALT  = 4'b1000
  } cssso_state_e;
endpackage

//--- src/cssso_alu.sv
`include "cssso_regs.svh"
module cssso_alu
  import cssso_pkg::*;
(
  // operation select
  input  wire logic [7:0] op,
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] m_in,
  input  wire logic       c_in,
  // result
  output logic      [7:0] res,
  output logic            c_out,
  output logic            v_out,
  output logic            c_valid,
  output logic            v_valid
);
  logic [8:0] diff;
  always_comb begin
    diff    = {1'b0, a_in} - {1'b0, m_in} - {8'h00, ~c_in};
    res     = m_in;
    c_out   = c_in;
    v_out   = 1'b0;
    c_valid = 1'b0;
    v_valid = 1'b0;
    case (op)
      `CSSSO_OP_ROL_A, `CSSSO_OP_ROL_ZP: begin
        res     = {m_in[6:0], c_in};
        c_out   = m_in[7];
        c_valid = 1'b1;
      end
      `CSSSO_OP_ROR_A, `CSSSO_OP_ROR_ZP: begin
        res     = {c_in, m_in[7:1]};
        c_out   = m_in[0];
        c_valid = 1'b1;
      end
      `CSSSO_OP_NIB_ZP: res = {m_in[3:0], m_in[7:4]};
      `CSSSO_OP_SBC_IMM, `CSSSO_OP_SBC_ZP: begin
        res     = diff[7:0];
        c_out   = ~diff[8];
        v_out   = (a_in[7] ^ m_in[7]) & (a_in[7] ^ diff[7]);
        c_valid = 1'b1;
        v_valid = 1'b1;
      end
      default: res = m_in | (8'h01 << op[7:5]);
    endcase
  end
endmodule

//--- bench/cssso_mem_model.sv
module cssso_mem_model (
  // memory bus from the core
  input  wire logic        sys_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  // read data, asynchronous
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ram [0:65535];
  assign mem_rdata = ram[mem_addr];
  always @(posedge sys_clk) begin
    if (mem_we === 1'b1) begin
      ram[mem_addr] <= mem_wdata;
    end
  end
endmodule

//--- bench/cssso_core_checker.sv
module cssso_core_checker
  import cssso_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // memory bus
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_rdata,
  // state
  input wire logic        fast_clock_output_pin_en,
  input wire logic        osc_run,
  input wire logic        instr_done,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  index_x,
  input wire logic [7:0]  index_y,
  input wire logic [7:0]  stack_ptr,
  input wire logic [7:0]  status,
  input wire logic [15:0] prog_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic first;
  logic next_first;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // opcode cycle follows reset or the end of an instruction
  always_comb next_first = reset | instr_done;
  always_ff @(posedge sys_clk) first <= next_first;
  sequence s_op(logic [7:0] code);
    first && mem_rdata == code;
  endsequence
  sequence s_done2;
    !instr_done ##1 instr_done;
  endsequence
  chk_push_acc_write: assert property (s_op(8'h48) |-> ##2 instr_done && mem_we
    && mem_wdata == acc && mem_addr == {8'h01, stack_ptr}
    ##1 stack_ptr == $past(stack_ptr) - 8'h01)
    else $error("push of accumulator wrong");
  chk_push_status: assert property (s_op(8'h08) |-> ##2 instr_done && mem_we
    && mem_wdata == status ##1 stack_ptr == $past(stack_ptr) - 8'h01)
    else $error("push of status wrong");
  chk_pull_acc_load: assert property (s_op(8'h68) |-> ##3 instr_done
    ##1 acc == $past(mem_rdata) && stack_ptr == $past(stack_ptr, 4) + 8'h01)
    else $error("pull of accumulator wrong");
  chk_carry_set: assert property (s_op(8'h38) |-> s_done2 ##1 status[0])
    else $error("carry not set");
  chk_mode_set: assert property (s_op(8'h32) |-> s_done2 ##1 status[5])
    else $error("index mode flag not set");
  chk_osc_stop: assert property (s_op(8'h42) |-> s_done2 ##1 !osc_run[*8])
    else $error("oscillator still running");
  chk_slow_detach: assert property (s_op(8'hc2) |-> s_done2
    ##1 !fast_clock_output_pin_en)
    else $error("fast clock pin still fed");
  chk_store_acc: assert property (s_op(8'h85) |-> !mem_we[*3] ##1 (instr_done
    && mem_we && mem_wdata == acc) ##1 status == $past(status, 4))
    else $error("store of accumulator wrong");
  chk_acc_to_x: assert property (s_op(8'haa) |-> s_done2
    ##1 index_x == $past(acc, 2) && status[1] == (index_x == 8'h00))
    else $error("accumulator to x wrong");
  chk_nibble_flags: assert property (s_op(8'h82) |-> ##7 instr_done && mem_we
    ##1 status == $past(status, 8))
    else $error("nibble rotate wrong");
  chk_irq_ret_len: assert property (s_op(8'h40) |-> !instr_done[*5]
    ##1 instr_done)
    else $error("interrupt return length wrong");
endmodule
bind cssso_core cssso_core_checker chk (
  .sys_clk(sys_clk), .reset(reset), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
  .fast_clock_output_pin_en(fast_clock_output_pin_en),
  .osc_run(osc_run), .instr_done(instr_done), .acc(acc),
  .index_x(index_x), .index_y(index_y), .stack_ptr(stack_ptr),
  .status(status), .prog_cnt(prog_cnt)
);

//--- bench/cpu_stack_shift_store_ops_tb.sv
module cpu_stack_shift_store_ops_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic [7:0]  mem_rdata;
  logic        fast_pin;
  logic        osc_run;
  logic        instr_done;
  logic [7:0]  acc;
  logic [7:0]  index_x;
  logic [7:0]  index_y;
  logic [7:0]  stack_ptr;
  logic [7:0]  status;
  logic [15:0] prog_cnt;
  int          miscompares = 0;
  int          compares = 0;
  logic        first = 1'b1;
  logic        tmode;
  logic [7:0]  op;
  int          n;
  always #50 sys_clk = ~sys_clk;
  cssso_core dut (
    .sys_clk(sys_clk), .reset(reset), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .fast_clock_output_pin_en(fast_pin), .osc_run(osc_run),
    .instr_done(instr_done), .acc(acc), .index_x(index_x),
    .index_y(index_y), .stack_ptr(stack_ptr), .status(status),
    .prog_cnt(prog_cnt)
  );
  cssso_mem_model mem (
    .sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem_rdata)
  );
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic int exp_cyc(input logic [7:0] o, input logic t);
    case (o)
      8'h48, 8'h08: return 3;
      8'h68, 8'h28: return 4;
      8'h26, 8'h66: return 5;
      8'h82: return 8;
      8'h40, 8'h60: return 6;
      8'he9: return t ? 5 : 2;
      8'he5: return t ? 6 : 3;
      8'h85, 8'h86, 8'h84: return 4;
      8'h64: return 3;
      default: return (o[4:0] == 5'h0f) ? 5 : 2;
    endcase
  endfunction
  // overflow of a borrow-free subtract
  function automatic logic sbc_ovf(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] r;
    r = a - m;
    return (a[7] ^ m[7]) & (a[7] ^ r[7]);
  endfunction
  // every instruction length measured from its opcode cycle
  always @(posedge sys_clk) begin
    if (reset === 1'b1) begin
      first = 1'b1;
    end else begin
      if (first) begin
        op = mem_rdata;
        tmode = status[5];
        n = 0;
      end
      n++;
      if (instr_done === 1'b1) begin
        check(n == exp_cyc(op, tmode), "instruction length");
      end
      first = (instr_done === 1'b1);
    end
  end
  task automatic prep();
    reset <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 512; i++) mem.ram[i] = 8'h00;
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) mem.ram[a + 16'(i)] = b[i];
  endtask
  task automatic go();
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 300 && osc_run !== 1'b0; i++) @(posedge sys_clk);
    // stay halted long enough for the halt assertion to finish
    repeat (10) @(posedge sys_clk);
    check(osc_run === 1'b0, "program did not halt");
    check(fast_pin === 1'b0, "fast clock pin");
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    logic [7:0] ra, rb, rc, rd, mx;
    logic [2:0] bi, bj;
    void'($urandom(32'h26b7));
    for (int k = 0; k < 5; k++) begin
      ra = (k == 0) ? 8'h00 : 8'($urandom);
      rd = (k == 0) ? 8'h01 : 8'($urandom);
      rb = 8'($urandom);
      rc = 8'($urandom);
      prep();
      put(16'h0000, '{8'h68, 8'haa, 8'h68, 8'ha8, 8'h85, 8'h80, 8'h86,
        8'h81, 8'h84, 8'h82, 8'h98, 8'h38, 8'h2a, 8'h6a, 8'h82, 8'h83,
        8'h48, 8'h8a, 8'hba, 8'h9a, 8'h08,
        k[0] ? 8'he5 : 8'he9, k[0] ? 8'h85 : rd, 8'h64, 8'h84,
        8'h78, 8'hf8, 8'hc2, 8'h42});
      put(16'h0100, '{ra, rb});
      put(16'h0083, '{rc});
      // odd passes take the subtrahend from zero page
      put(16'h0085, '{rd});
      go();
      check(acc === 8'(ra - rd), "subtract result");
      check(status[0] === (ra >= rd), "borrow flag");
      check(index_x === 8'h00, "stack to x");
      check(index_y === rb, "acc to y");
      check(stack_ptr === 8'hff, "stack wrap");
      check(mem.ram[16'h0080] === rb, "store acc");
      check(mem.ram[16'h0081] === ra, "store x");
      check(mem.ram[16'h0082] === rb, "store y");
      check(mem.ram[16'h0083] === {rc[3:0], rc[7:4]}, "nibble");
      check(mem.ram[16'h0101] === rb, "pushed acc");
      check(mem.ram[16'h0084] === 8'h00, "tested byte kept");
      check(status[7:1] === {1'b0, sbc_ovf(ra, rd), 5'b00111}, "flags");
    end
    for (int k = 0; k < 5; k++) begin
      ra = 8'($urandom);
      rb = 8'($urandom);
      rc = 8'($urandom);
      bi = 3'($urandom);
      bj = 3'($urandom % 4);
      prep();
      put(16'h0000, '{8'h28, 8'h40});
      put(16'h0100, '{8'($urandom), 8'h01, 8'h40, 8'h00, 8'h50, 8'h00});
      put(16'h0040, '{8'h60});
      put(16'h0050, '{8'h26, 8'h20, 8'h66, 8'h21, {bi, 5'h0f}, 8'h22,
        {bj, 5'h0b}, 8'haa, 8'h32, 8'he5, 8'h23, 8'hc2, 8'h42});
      put(16'h0020, '{ra, rb, 8'h00, rc});
      // x selects a byte in 0x01 to 0x08 that nothing but the subtract writes
      mx = mem.ram[16'(8'h01 << bj)] - rc - {7'h00, ~rb[0]};
      go();
      check(mem.ram[16'h0020] === {ra[6:0], 1'b1}, "rotate left");
      check(mem.ram[16'h0021] === {ra[7], rb[7:1]}, "rotate right");
      check(mem.ram[16'h0022] === 8'h01 << bi, "bit set mem");
      check(acc === 8'h01 << bj, "bit set acc");
      check(index_x === 8'h01 << bj, "acc to x");
      check(status[5] === 1'b1, "index mode");
      check(mem.ram[16'(8'h01 << bj)] === mx, "indexed subtract");
    end
    end_sim();
  end
endmodule
